// [pkg/acr_regs.svh]
// Register offsets, field slices, reset values and timing constants
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH
`define ACR_CLK_MHZ 25
`define ACR_LO_PER_US 10000
`define ACR_HI_PER_US 2500
`define ACR_A_CTRL1 7'h20
`define ACR_A_CTRL2 7'h21
`define ACR_A_CTRL3 7'h22
`define ACR_A_HPRST 7'h23
`define ACR_A_STAT 7'h27
`define ACR_A_OUTX 7'h29
`define ACR_A_OUTY 7'h2B
`define ACR_A_WCFG 7'h30
`define ACR_A_WSRC 7'h31
`define ACR_A_WTHS 7'h32
`define ACR_RST_CTRL1 8'h07
`define ACR_RST_ZERO 8'h00
`define ACR_C1_RATE 7
`define ACR_C1_PWR 6
`define ACR_C1_STP 4
`define ACR_C1_STM 3
`define ACR_C1_AXEN 1:0
`define ACR_C2_SIM 7
`define ACR_C2_BOOT 6
`define ACR_C2_FDS 4
`define ACR_C2_HPW2 3
`define ACR_C2_HPW1 2
`define ACR_C2_CUT 1:0
`define ACR_C3_POL 7
`define ACR_C3_OD 6
`define ACR_C3_SRC2 5:3
`define ACR_C3_SRC1 2:0
`define ACR_W_AOI 7
`define ACR_W_LIR 6
`define ACR_W_RES 5:4
`define ACR_W_EN 3:0
`define ACR_SRC_IA 6
`define ACR_TH_MODE 7
`define ACR_TH_VAL 6:0
`define ACR_PS_GND 3'h0
`define ACR_PS_WU1 3'h1
`define ACR_PS_WU2 3'h2
`define ACR_PS_ANY 3'h3
`define ACR_PS_DRDY 3'h4
`define ACR_ST_DELTA 8'h10
`define ACR_HP_BASE 4'h5
`define ACR_TRIM_N 2
`define ACR_TRIM0 8'h03
`define ACR_TRIM1 8'hFD
`endif

// [pkg/acr_pkg.sv]
// Shared types of the accelerometer control and status registers
package acr_pkg;
	typedef enum logic [0:0] {ACR_IDLE, ACR_COPY} acr_boot_e;
	typedef logic [7:0] acr_byte_t;
endpackage

// [core/accel_control_status_regs.sv]
// Control, status, output and wake-up register logic of a two-axis accelerometer
//
// Operation
// - Data rate field picks 100 or 400 Hz
// - Power field zero keeps device powered down
// - Self-test fields shift the measured outputs
// - Y data-ready only while Y enabled
// - X data-ready only while X enabled
// - Wire-mode picks which pad carries read data
// - Reboot copies trims, then clears itself
// - Filtered-output field feeds high-pass data out
// - Unit-one enable feeds filtered data to unit one; the unit-two enable is not used
// - Cut-off code sets high-pass corner frequency
// - Polarity field selects active high or low
// - Drive-type field selects push-pull or open drain
// - Reading filter-reset register loads filter state with the current sample
// - New-data flags per axis and combined
// - Overrun flags when unread sample replaced
// - Unit one combines events by OR or AND
// - Latch field holds request until source read
// - Four enables for above and below threshold
// - Source read clears register and its interrupt
// - Threshold holds seven bits plus counter mode
`timescale 1ns/1ns
`include "acr_regs.svh"
module accel_control_status_regs #(
	parameter int LO_DIV = `ACR_LO_PER_US * `ACR_CLK_MHZ,
	parameter int HI_DIV = `ACR_HI_PER_US * `ACR_CLK_MHZ
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Register port from the serial framer
	input wire logic [6:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// Serial read data to be routed to a pad
	input wire logic serDataOut,
	input wire logic serDrive,
	output logic sdoOut,
	output logic sdoOe,
	output logic sharedOut,
	output logic sharedOe,
	// Converter samples and second wake-up unit
	input wire logic [7:0] rawX,
	input wire logic [7:0] rawY,
	input wire logic wakeTwoIrq,
	// Interrupt pads
	output logic irq1Out,
	output logic irq1Oe,
	output logic irq2Out,
	output logic irq2Oe
);
	// ********************************
	// Declarations
	// ********************************
	localparam logic [7:0] TRIM_ROM [`ACR_TRIM_N] = '{`ACR_TRIM0, `ACR_TRIM1};
	logic [7:0] ctrl1, ctrl2, ctrl3, wakeCfg, wakeThs, next_ctrl1, next_ctrl2;
	logic [7:0] next_ctrl3, next_wakeCfg, next_wakeThs, next_regRdData;
	logic [7:0] cal [`ACR_TRIM_N];
	acr_pkg::acr_boot_e bootState, next_bootState;
	logic [17:0] rateCnt, rateLim;
	logic tick, active, hpClear, rdSrc, anyTick;
	logic [1:0] axEn, tickAx, rdAx, newF, ovrF, next_newF, next_ovrF;
	logic xyNew, xyOvr, next_xyNew, next_xyOvr;
	logic [7:0] raw [2];
	logic [7:0] meas [2];
	logic [7:0] hp [2];
	logic [7:0] outR [2];
	logic [15:0] lp [2];
	logic [3:0] ev, srcEv, next_srcEv;
	logic srcIa, next_srcIa, wakeOne, evHit;

	// Pad level for a source code; codes outside the table drive ground
	function automatic logic padLevel(input logic [2:0] code, input logic w1,
			input logic w2, input logic drdy);
		unique case (code)
			`ACR_PS_WU1: padLevel = w1;
			`ACR_PS_WU2: padLevel = w2;
			`ACR_PS_ANY: padLevel = w1 | w2;
			`ACR_PS_DRDY: padLevel = drdy;
			default: padLevel = 1'b0;
		endcase
	endfunction

	// ********************************
	// Sample rate and power
	// ********************************
	// Rate divider: one enable pulse per output sample
	assign rateLim = ctrl1[`ACR_C1_RATE] ? 18'(HI_DIV - 1) : 18'(LO_DIV - 1);
	assign tick = rateCnt >= rateLim;
	assign active = ctrl1[`ACR_C1_PWR];
	assign axEn = ctrl1[`ACR_C1_AXEN];
	assign tickAx = {2{tick & active}} & axEn;
	assign anyTick = |tickAx;
	assign raw[0] = rawX;
	assign raw[1] = rawY;
	assign hpClear = regRdEn && regAddr == `ACR_A_HPRST;
	assign rdAx = {regRdEn && regAddr == `ACR_A_OUTY, regRdEn && regAddr == `ACR_A_OUTX};
	assign rdSrc = regRdEn && regAddr == `ACR_A_WSRC;

	// Divider follows a rate change through the compare, not a reload
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rateCnt <= '0;
		end else begin
			rateCnt <= tick ? '0 : rateCnt + 18'h00001;
		end
	end

	// ********************************
	// Per-axis measurement and filter
	// ********************************
	for (genvar i = 0; i < 2; i++) begin : g_axis
		logic [7:0] stAdj;
		logic [15:0] diff, next_lp;
		logic [7:0] next_out;
		// Self test pushes plus and minus in opposite senses
		always_comb begin
			stAdj = 8'h00;
			if (ctrl1[`ACR_C1_STP]) stAdj = stAdj + `ACR_ST_DELTA;
			if (ctrl1[`ACR_C1_STM]) stAdj = stAdj - `ACR_ST_DELTA;
			meas[i] = raw[i] + cal[i] + stAdj;
			diff = {meas[i], 8'h00} - lp[i];
			// Corner scales with the rate, so one shift serves both rates
			next_lp = lp[i] + 16'($signed(diff) >>> (`ACR_HP_BASE + ctrl2[`ACR_C2_CUT]));
			hp[i] = meas[i] - lp[i][15:8];
			next_out = outR[i];
			if (hpClear) begin
				next_lp = {meas[i], 8'h00};
				if (ctrl2[`ACR_C2_FDS]) next_out = 8'h00;
			end else if (tickAx[i]) begin
				next_out = ctrl2[`ACR_C2_FDS] ? hp[i] : meas[i];
			end else if (!(tick & active)) begin
				next_lp = lp[i];
			end
		end
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				lp[i] <= '0;
				outR[i] <= `ACR_RST_ZERO;
			end else begin
				lp[i] <= next_lp;
				outR[i] <= next_out;
			end
		end
	end

	// ********************************
	// Status flags
	// ********************************
	// Set wins over the clear caused by a read in the same cycle
	always_comb begin
		next_newF = tickAx | (newF & ~rdAx);
		next_ovrF = (tickAx & newF) | (ovrF & ~rdAx);
		next_xyNew = anyTick | (xyNew & |(newF & ~rdAx));
		next_xyOvr = (anyTick & xyNew) | (xyOvr & |(ovrF & ~rdAx));
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			newF <= '0;
			ovrF <= '0;
			xyNew <= 1'b0;
			xyOvr <= 1'b0;
		end else begin
			newF <= next_newF;
			ovrF <= next_ovrF;
			xyNew <= next_xyNew;
			xyOvr <= next_xyOvr;
		end
	end

	// ********************************
	// Wake-up unit one
	// ********************************
	// Threshold compare on signed data, nine bits to avoid wrap
	always_comb begin
		logic [7:0] dx, dy;
		logic signed [8:0] th;
		dx = ctrl2[`ACR_C2_HPW1] ? hp[0] : meas[0];
		dy = ctrl2[`ACR_C2_HPW1] ? hp[1] : meas[1];
		th = $signed({2'b00, wakeThs[`ACR_TH_VAL]});
		ev[3] = $signed({dy[7], dy}) > th;
		ev[2] = $signed({dy[7], dy}) < -th;
		ev[1] = $signed({dx[7], dx}) > th;
		ev[0] = $signed({dx[7], dx}) < -th;
		ev = ev & wakeCfg[`ACR_W_EN];
		evHit = wakeCfg[`ACR_W_AOI]
			? (&(ev | ~wakeCfg[`ACR_W_EN])) & (|wakeCfg[`ACR_W_EN])
			: |ev;
		next_srcEv = rdSrc ? 4'h0 : srcEv;
		next_srcIa = rdSrc ? 1'b0 : srcIa;
		if (tick & active) begin
			if (!wakeCfg[`ACR_W_LIR]) begin
				next_srcEv = ev;
				next_srcIa = evHit;
			end else if (!srcIa || rdSrc) begin
				next_srcEv = ev;
				next_srcIa = evHit;
			end
		end
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			srcEv <= '0;
			srcIa <= 1'b0;
		end else begin
			srcEv <= next_srcEv;
			srcIa <= next_srcIa;
		end
	end
	assign wakeOne = srcIa;

	// ********************************
	// Registers, reboot and read port
	// ********************************
	// Writes, and the reboot sequencer that runs at reset and on request
	always_comb begin
		next_ctrl1 = ctrl1;
		next_ctrl2 = ctrl2;
		next_ctrl3 = ctrl3;
		next_wakeCfg = wakeCfg;
		next_wakeThs = wakeThs;
		next_bootState = bootState;
		if (regWrEn) begin
			unique case (regAddr)
				`ACR_A_CTRL1: next_ctrl1 = regWrData;
				`ACR_A_CTRL2: next_ctrl2 = regWrData;
				`ACR_A_CTRL3: next_ctrl3 = regWrData;
				`ACR_A_WCFG: next_wakeCfg = regWrData;
				`ACR_A_WTHS: next_wakeThs = regWrData;
				default: ;
			endcase
		end
		if (regWrEn && regAddr == `ACR_A_CTRL2 && regWrData[`ACR_C2_BOOT]) begin
			next_bootState = acr_pkg::ACR_COPY;
		end else if (bootState == acr_pkg::ACR_COPY) begin
			next_bootState = acr_pkg::ACR_IDLE;
		end
		next_ctrl2[`ACR_C2_BOOT] = 1'b0;
		next_regRdData = regRdData;
		if (regRdEn) begin
			unique case (regAddr)
				`ACR_A_CTRL1: next_regRdData = ctrl1;
				`ACR_A_CTRL2: next_regRdData = ctrl2 | {1'b0, bootState == acr_pkg::ACR_COPY,
					6'h00};
				`ACR_A_CTRL3: next_regRdData = ctrl3;
				`ACR_A_STAT: next_regRdData = {xyOvr, 1'b0, ovrF, xyNew, 1'b0, newF};
				`ACR_A_OUTX: next_regRdData = outR[0];
				`ACR_A_OUTY: next_regRdData = outR[1];
				`ACR_A_WCFG: next_regRdData = wakeCfg;
				`ACR_A_WSRC: next_regRdData = {1'b0, srcIa, 2'b00, srcEv};
				`ACR_A_WTHS: next_regRdData = wakeThs;
				default: next_regRdData = 8'h00;
			endcase
		end
	end
	// Whole trim table is copied in one cycle, so the copy state lasts one cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl1 <= `ACR_RST_CTRL1;
			ctrl2 <= `ACR_RST_ZERO;
			ctrl3 <= `ACR_RST_ZERO;
			wakeCfg <= `ACR_RST_ZERO;
			wakeThs <= `ACR_RST_ZERO;
			bootState <= acr_pkg::ACR_COPY;
			regRdData <= `ACR_RST_ZERO;
			cal <= '{default: `ACR_RST_ZERO};
		end else begin
			ctrl1 <= next_ctrl1;
			ctrl2 <= next_ctrl2;
			ctrl3 <= next_ctrl3;
			wakeCfg <= next_wakeCfg;
			wakeThs <= next_wakeThs;
			bootState <= next_bootState;
			regRdData <= next_regRdData;
			if (bootState == acr_pkg::ACR_COPY) cal <= TRIM_ROM;
		end
	end

	// ********************************
	// Pads
	// ********************************
	// Registered pad drivers; open drain only drives the asserted level
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sdoOut <= 1'b0;
			sdoOe <= 1'b0;
			sharedOut <= 1'b0;
			sharedOe <= 1'b0;
			irq1Out <= 1'b0;
			irq1Oe <= 1'b0;
			irq2Out <= 1'b0;
			irq2Oe <= 1'b0;
		end else begin
			sdoOut <= serDataOut;
			sharedOut <= serDataOut;
			sdoOe <= serDrive & ~ctrl2[`ACR_C2_SIM];
			sharedOe <= serDrive & ctrl2[`ACR_C2_SIM];
			irq1Out <= padLevel(ctrl3[`ACR_C3_SRC1], wakeOne, wakeTwoIrq, xyNew)
				^ ctrl3[`ACR_C3_POL];
			irq1Oe <= ~ctrl3[`ACR_C3_OD]
				| padLevel(ctrl3[`ACR_C3_SRC1], wakeOne, wakeTwoIrq, xyNew);
			irq2Out <= padLevel(ctrl3[`ACR_C3_SRC2], wakeOne, wakeTwoIrq, xyNew)
				^ ctrl3[`ACR_C3_POL];
			irq2Oe <= ~ctrl3[`ACR_C3_OD]
				| padLevel(ctrl3[`ACR_C3_SRC2], wakeOne, wakeTwoIrq, xyNew);
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_rate_wrap: assert property (tick |=> rateCnt == 18'h00000)
		else $error("divider did not restart after a sample");
	a_power_down: assert property (!active && !newF[0] |=> !newF[0])
		else $error("sample flagged while powered down");
	a_y_gate: assert property (!axEn[1] && !newF[1] |=> !newF[1])
		else $error("Y flag set while Y disabled");
	a_x_gate: assert property (!axEn[0] && !newF[0] |=> !newF[0])
		else $error("X flag set while X disabled");
	a_wire_mode: assert property (serDrive && ctrl2[`ACR_C2_SIM] |=> sharedOe && !sdoOe)
		else $error("three-wire read not on shared pad");
	a_boot_clear: assert property ($rose(bootState == acr_pkg::ACR_COPY)
		|-> ##[1:2] bootState == acr_pkg::ACR_IDLE)
		else $error("reboot did not clear itself");
	a_filter_zero: assert property (hpClear && ctrl2[`ACR_C2_FDS]
		|=> outR[0] == 8'h00 && outR[1] == 8'h00)
		else $error("filter reset did not zero outputs");
	a_overrun_set: assert property (tickAx[0] && newF[0] |=> ovrF[0] && xyOvr)
		else $error("overrun not flagged");
	a_read_clear: assert property (rdAx[0] && !tickAx[0] |=> !newF[0] && !ovrF[0])
		else $error("X read did not clear flags");
	a_latch_hold: assert property (wakeCfg[`ACR_W_LIR] && srcIa && !rdSrc |=> srcIa)
		else $error("latched request lost before read");
	a_pad_push: assert property (!ctrl3[`ACR_C3_OD] |=> irq1Oe && irq2Oe)
		else $error("push-pull pad not driven");
	c_reboot: cover property (regWrEn && regAddr == `ACR_A_CTRL2 && regWrData[`ACR_C2_BOOT]);
	c_overrun: cover property (tickAx[0] && newF[0]);
	c_hp_clear: cover property (hpClear && ctrl2[`ACR_C2_FDS]);
	c_latched: cover property (wakeCfg[`ACR_W_LIR] && srcIa ##1 rdSrc);
endmodule

// [verif/acr_host_model.sv]
// Host side of the register port: single byte write and read cycles
`timescale 1ns/1ns
module acr_host_model (
	// Clock
	input wire logic mclk,
	// Register port toward the device
	output logic [6:0] regAddr,
	output logic regWrEn,
	output logic regRdEn,
	output logic [7:0] regWrData,
	input wire logic [7:0] regRdData
);
	// Idle port from time zero so no strobe floats
	initial begin
		regAddr = 7'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regWrData = 8'h00;
	end

	// One-cycle write strobe; data is passed through unchecked, and one caller writes all ones to the read-only status address
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge mclk);
		#1;
		regWrEn = 1'b0;
		regWrData = ~d; // Stale data never lingers on the bus
	endtask

	// One-cycle read strobe; the registered answer is taken after that edge
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge mclk);
		#1;
		regRdEn = 1'b0;
		d = regRdData;
	endtask
endmodule

// [verif/testbench.sv]
// Self-checking bench for the accelerometer control and status registers
`timescale 1ns/1ns
`include "acr_regs.svh"
module testbench;
	localparam int LO = 40;
	localparam int HI = 10;
	// ****
	// Wiring
	// ****
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [6:0] regAddr;
	logic regWrEn;
	logic regRdEn;
	acr_pkg::acr_byte_t regWrData;
	acr_pkg::acr_byte_t regRdData;
	logic serDataOut = 1'b0;
	logic serDrive = 1'b0;
	acr_pkg::acr_byte_t rawX = 8'h12;
	acr_pkg::acr_byte_t rawY = 8'hE5;
	logic wakeTwoIrq = 1'b0;
	logic sdoOut;
	logic sdoOe;
	logic sharedOut;
	logic sharedOe;
	logic irq1Out;
	logic irq1Oe;
	logic irq2Out;
	logic irq2Oe;
	acr_pkg::acr_byte_t d;
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	// Pads gathered into one byte so one compare task serves all
	wire logic [7:0] pads = {irq2Out, irq2Oe, irq1Out, irq1Oe, sharedOut, sharedOe, sdoOut, sdoOe};

	// Clock, and a cycle count used to time sample ticks
	always #20 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	// Short divider counts keep the run brief
	accel_control_status_regs #(.LO_DIV(LO), .HI_DIV(HI)) u_dut (
		.mclk, .arst_n, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData,
		.serDataOut, .serDrive, .sdoOut, .sdoOe, .sharedOut, .sharedOe,
		.rawX, .rawY, .wakeTwoIrq, .irq1Out, .irq1Oe, .irq2Out, .irq2Oe
	);
	acr_host_model u_h (.mclk, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData);

	// ****
	// Helpers
	// ****
	// Masked byte compare; unknown bits never match
	task automatic chk(input acr_pkg::acr_byte_t got, exp, m);
		compares++;
		if ((got & m) !== (exp & m)) begin
			fail_count++;
			$display("BAD %0t got %h want %h mask %h", $time, got, exp, m);
		end
	endtask
	task automatic rchk(input logic [6:0] a, input acr_pkg::acr_byte_t e, m);
		u_h.rd(a, d);
		chk(d, e, m);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Reading both outputs drops all fresh-sample flags
	task automatic clr();
		u_h.rd(`ACR_A_OUTX, d);
		u_h.rd(`ACR_A_OUTY, d);
	endtask
	// Poll status until a fresh X sample shows, bounded
	task automatic wnew();
		for (int i = 0; i < 100; i++) begin
			u_h.rd(`ACR_A_STAT, d);
			if (d[0] === 1'b1) break;
		end
		chk(d, 8'h01, 8'h01);
	endtask

	// ****
	// Scenarios
	// ****
	task automatic s_reset();
		chk(pads, 8'h50, 8'hF0);
		rchk(`ACR_A_CTRL1, 8'h07, 8'hFF);
		rchk(`ACR_A_CTRL2, 8'h00, 8'hFF);
		rchk(`ACR_A_CTRL3, 8'h00, 8'hFF);
		rchk(`ACR_A_WCFG, 8'h00, 8'hFF);
		wt(2 * LO);
		rchk(`ACR_A_STAT, 8'h00, 8'hFF);
		rchk(7'h24, 8'h00, 8'hFF);
		u_h.wr(`ACR_A_STAT, 8'hFF);
		rchk(`ACR_A_STAT, 8'h00, 8'hFF);
		u_h.wr(`ACR_A_CTRL2, 8'h9F);
		rchk(`ACR_A_CTRL2, 8'h9F, 8'hFF);
		u_h.wr(`ACR_A_WCFG, 8'hCF);
		rchk(`ACR_A_WCFG, 8'hCF, 8'hFF);
		u_h.wr(`ACR_A_WTHS, 8'hFF);
		rchk(`ACR_A_WTHS, 8'hFF, 8'hFF);
		u_h.wr(`ACR_A_CTRL2, 8'h40);
		wt(3);
		rchk(`ACR_A_CTRL2, 8'h00, 8'hFF);
		u_h.wr(`ACR_A_WCFG, 8'h00);
		u_h.wr(`ACR_A_WTHS, 8'h18);
	endtask
	// Time between two fresh samples must match the selected rate
	task automatic s_rate(input acr_pkg::acr_byte_t c, input int p);
		int t;
		logic ok;
		u_h.wr(`ACR_A_CTRL1, c);
		clr();
		wnew();
		t = cyc;
		clr();
		wnew();
		ok = (cyc - t >= p - 2) && (cyc - t <= p + 2);
		chk({7'h00, ok}, 8'h01, 8'h01);
	endtask
	task automatic s_flags();
		u_h.wr(`ACR_A_CTRL1, 8'h43);
		clr();
		wnew();
		wt(2 * LO);
		rchk(`ACR_A_STAT, 8'hBB, 8'hFF);
		rchk(`ACR_A_OUTX, 8'(8'h12 + `ACR_TRIM0), 8'hFF);
		rchk(`ACR_A_STAT, 8'h00, 8'h11);
		rchk(`ACR_A_OUTY, 8'(8'hE5 + `ACR_TRIM1), 8'hFF);
		rchk(`ACR_A_STAT, 8'h00, 8'h3B);
		u_h.wr(`ACR_A_CTRL1, 8'h41);
		clr();
		wt(LO + 4);
		rchk(`ACR_A_STAT, 8'h01, 8'h03);
		u_h.wr(`ACR_A_CTRL1, 8'h42);
		clr();
		wt(LO + 4);
		rchk(`ACR_A_STAT, 8'h02, 8'h03);
		u_h.wr(`ACR_A_CTRL1, 8'h53);
		wt(LO + 4);
		rchk(`ACR_A_OUTX, 8'(8'h12 + `ACR_TRIM0 + `ACR_ST_DELTA), 8'hFF);
		u_h.wr(`ACR_A_CTRL1, 8'h4B);
		wt(LO + 4);
		rchk(`ACR_A_OUTX, 8'(8'h12 + `ACR_TRIM0 - `ACR_ST_DELTA), 8'hFF);
		u_h.wr(`ACR_A_CTRL1, 8'h43);
	endtask
	// Filter reset read zeroes both filtered outputs at once
	task automatic s_filter();
		u_h.wr(`ACR_A_CTRL2, 8'h10);
		wnew();
		rchk(`ACR_A_HPRST, 8'h00, 8'hFF);
		rchk(`ACR_A_OUTX, 8'h00, 8'hFF);
		rchk(`ACR_A_OUTY, 8'h00, 8'hFF);
		u_h.wr(`ACR_A_CTRL2, 8'h00);
	endtask
	task automatic s_wire();
		serDrive = 1'b1;
		serDataOut = 1'b1;
		wt(2);
		chk(pads, 8'h03, 8'h07);
		u_h.wr(`ACR_A_CTRL2, 8'h80);
		serDataOut = 1'b0;
		wt(2);
		chk(pads, 8'h04, 8'h0D);
		serDataOut = 1'b1;
		wt(2);
		chk(pads, 8'h0C, 8'h0D);
		u_h.wr(`ACR_A_CTRL2, 8'h00);
		serDrive = 1'b0;
	endtask
	task automatic s_pads();
		wakeTwoIrq = 1'b1;
		for (int c = 0; c < 4; c++) begin
			u_h.wr(`ACR_A_CTRL3, 8'(c << 3));
			wt(2);
			chk(pads, {c[1], 7'h40}, 8'hC0);
		end
		wakeTwoIrq = 1'b0;
		u_h.wr(`ACR_A_CTRL3, 8'h04);
		clr();
		wnew();
		wt(2);
		chk(pads, 8'h30, 8'h30);
		u_h.wr(`ACR_A_CTRL3, 8'h84);
		wt(2);
		chk(pads, 8'h10, 8'h30);
		u_h.wr(`ACR_A_CTRL3, 8'h44);
		wt(2);
		chk(pads, 8'h30, 8'h30);
		clr();
		wt(2);
		chk(pads, 8'h00, 8'h10);
	endtask
	task automatic s_wake();
		u_h.wr(`ACR_A_CTRL3, 8'h01);
		u_h.wr(`ACR_A_WCFG, 8'h04);
		wt(LO + 4);
		chk(pads, 8'h30, 8'h30);
		rchk(`ACR_A_WSRC, 8'h44, 8'hFF);
		wt(1);
		chk(pads, 8'h00, 8'h20);
		u_h.wr(`ACR_A_WCFG, 8'h86);
		wt(LO + 4);
		rchk(`ACR_A_WSRC, 8'h00, 8'h40);
		u_h.wr(`ACR_A_WCFG, 8'h44);
		wt(LO + 4);
		rawY = 8'h00;
		wt(LO + 4);
		rchk(`ACR_A_WSRC, 8'h44, 8'hFF);
		rchk(`ACR_A_WSRC, 8'h00, 8'hFF);
		rawY = 8'hE5;
		// Filtered wake path sees zero right after a filter reset, so no event
		u_h.wr(`ACR_A_CTRL2, 8'h04);
		u_h.wr(`ACR_A_WCFG, 8'h04);
		rchk(`ACR_A_HPRST, 8'h00, 8'hFF);
		wt(LO + 4);
		rchk(`ACR_A_WSRC, 8'h00, 8'h40);
	endtask

	// ****
	// Verdict, watchdog and main sequence
	// ****
	task automatic give_verdict();
		$display("Compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Whole run needs about a thousand cycles; this bound is generous
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		wt(2);
		s_reset();
		s_rate(8'h43, LO);
		s_rate(8'hC3, HI);
		s_flags();
		s_filter();
		s_wire();
		s_pads();
		s_wake();
		give_verdict();
	end
endmodule
